// ==== testbench/mss_far_model.sv ====
// Far-side model: modems on the lines and the interrupt bus arbiter
module mss_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [63:0] modem_set_i,
    input  wire logic [3:0]  grant_dly_i,
    output logic      [15:0] carrier_o,
    output logic      [15:0] cts_o,
    output logic      [15:0] srx_o,
    output logic      [15:0] ring_o,
    input  wire logic        bus_request_line_i,
    input  wire logic        intr_xfer_i,
    output logic             bus_grant_o,
    output logic             intr_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] wait_cnt;
    // Modem levels as commanded, steady between changes
    assign {ring_o, carrier_o, cts_o, srx_o} = modem_set_i;
    // Grant after a chosen delay, end the transfer no sooner
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wait_cnt    <= 5'h00;
            bus_grant_o <= 1'b0;
            intr_done_o <= 1'b0;
        end else begin
            wait_cnt    <= (bus_request_line_i || intr_xfer_i) ? wait_cnt + 5'h01 : 5'h00;
            bus_grant_o <= bus_request_line_i && (wait_cnt >= {1'b0, grant_dly_i});
            intr_done_o <= intr_xfer_i && (wait_cnt >= {1'b0, grant_dly_i});
        end
    end
endmodule // mss_far_model

// ==== testbench/mss_scanner_tb.sv ====
// Self-checking bench for the modem status scanner
module mss_scanner_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mss_pkg::*;
    localparam logic [7:0]  A_CSR  = {IDX_CSR, 2'b00};
    localparam logic [7:0]  A_LINE = {IDX_LINE, 2'b00};
    localparam logic [63:0] M5     = 64'h0020_0020_0020_0020;
    logic        clk_i, rst_n_i, cyc, stb, we, ack, br, gnt, xfer, idone;
    logic        br_seen = 1'b0;
    logic [7:0]  adr, vec;
    logic [3:0]  sel, gdly, l;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] car, cts, srx, ring, trdy, rts, stx;
    logic [2:0]  lvl;
    logic [63:0] mset;
    logic [3:0]  out_m [16];
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    mss_scanner i_mss_scanner (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .carrier_i(car),
        .clear_to_send_i(cts), .secondary_receive_status_i(srx), .ring_i(ring), .terminal_ready_o(trdy),
        .request_to_send_control_o(rts), .secondary_transmit_control_o(stx), .bus_request_line_o(br),
        .bus_request_level_o(lvl), .bus_grant_i(gnt), .intr_xfer_o(xfer), .intr_vector_o(vec),
        .intr_done_i(idone));
    mss_far_model i_mss_far_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .modem_set_i(mset), .grant_dly_i(gdly),
        .carrier_o(car), .cts_o(cts), .srx_o(srx), .ring_o(ring), .bus_request_line_i(br),
        .intr_xfer_i(xfer), .bus_grant_o(gnt), .intr_done_o(idone));

    // Clock, 4 ns period
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Hang guard and request watcher
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (br === 1'b1) br_seen <= 1'b1;
        if (cycles == 80000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle; read data lands in rd
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdat;
        if (n >= 40) chk(64'h0, 64'h1, "bus ack");
        {cyc, stb} <= 2'b00;
    endtask

    // Control write that keeps the current line number
    task automatic set_csr(input logic [3:0] ctl);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        wb(1'b1, A_CSR, {24'h0, ctl, rd[3:0]}, 4'h1);
    endtask

    // Wait for request, grant and transfer; check vector and done
    task automatic take_irq();
        int n;
        n = 0;
        while (xfer !== 1'b1 && n < 6000) begin
            @(posedge clk_i);
            n++;
        end
        chk(64'(xfer), 64'h1, "interrupt transfer");
        chk({56'h0, vec}, {56'h0, VECTOR_DEF}, "vector");
        chk(64'(lvl), 64'(BR_LEVEL), "request level");
        while (xfer === 1'b1 && n < 6100) begin
            @(posedge clk_i);
            n++;
        end
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd[CSR_DONE]), 64'h1, "done after change");
    endtask

    function automatic logic [31:0] csr_exp(input logic [3:0] ln);
        logic [3:0] st;
        st = out_m[ln][OUT_LEN] ? {mset[48+ln], mset[32+ln], mset[16+ln], mset[ln]} : 4'h0;
        return {8'h00, st, out_m[ln], 12'h000, ln};
    endfunction

    function automatic logic [15:0] ctl_vec(input int b);
        logic [15:0] v;
        foreach (out_m[j]) v[j] = out_m[j][b];
        return v;
    endfunction

    initial begin
        void'($urandom(72));
        {cyc, stb, we, adr, wdat, sel} = '0;
        rst_n_i = 1'b0;
        gdly = 4'h0;
        mset = {$urandom, $urandom};
        foreach (out_m[i]) out_m[i] = 4'h0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Wait out the clear sweep
        rd = 32'h200;
        for (int n = 0; n < 40 && rd[CSR_CLRCYC] !== 1'b0; n++) wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd), 64'(csr_exp(4'h0)), "csr reset");
        // Unmapped address and a write without byte lane 0 have no effect
        wb(1'b1, 8'h04, 32'hff, 4'hf);
        wb(1'b0, 8'h04, 32'h0, 4'hf);
        chk(64'(rd), 64'h0, "unmapped read");
        wb(1'b1, A_CSR, 32'h0f, 4'he);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd), 64'(csr_exp(4'h0)), "high byte write");
        // Outgoing controls on edge and random lines
        for (int i = 0; i < 12; i++) begin
            l = (i < 2) ? 4'(i * 15) : 4'($urandom);
            out_m[l] = 4'($urandom);
            wb(1'b1, A_CSR, {28'h0, l}, 4'h1);
            wb(1'b1, A_LINE, {28'h0, out_m[l]}, 4'h1);
            wb(1'b0, A_CSR, 32'h0, 4'hf);
            chk(64'(rd), 64'(csr_exp(l)), "csr readback");
            chk(64'({trdy, rts, stx}), 64'({ctl_vec(OUT_TRDY), ctl_vec(OUT_RTS), ctl_vec(OUT_STX)}), "ctl");
        end
        // Single step wraps line 15 to 0 and clears itself
        wb(1'b1, A_CSR, 32'h1f, 4'h1);
        repeat (6 * STATE_CYC) @(posedge clk_i);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd[4:0]), 64'h0, "step");
        // Only line 5 enabled, modems quiet
        mset <= 64'h0;
        for (int j = 0; j < 16; j++) begin
            out_m[j] = (j == 5) ? 4'h1 : 4'h0;
            wb(1'b1, A_CSR, 32'(j), 4'h1);
            wb(1'b1, A_LINE, {28'h0, out_m[j]}, 4'h1);
        end
        // Free run from line 15 for ten line times
        set_csr(4'h2);
        repeat (10 * 4 * STATE_CYC) @(posedge clk_i);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd[3:0] inside {4'h8, 4'h9, 4'ha}), 64'h1, "scan rate");
        // Ring rise with interrupts off: done but no request
        mset[53] <= 1'b1;
        repeat (20 * 4 * STATE_CYC) @(posedge clk_i);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'(rd[CSR_DONE]), 64'h1, "ring rise");
        chk(64'(br_seen), 64'h0, "request while disabled");
        // Ring fall is no condition
        mset[53] <= 1'b0;
        set_csr(4'h6);
        repeat (20 * 4 * STATE_CYC) @(posedge clk_i);
        wb(1'b0, A_CSR, 32'h0, 4'hf);
        chk(64'({rd[CSR_DONE], br_seen}), 64'h0, "ring fall");
        // Both edges of the other circuits; noise on disabled lines
        for (int k = 0; k < 6; k++) begin
            gdly <= 4'($urandom) & 4'h7;
            // Line 5 carries only the circuit under test, high on even steps
            mset <= ({$urandom, $urandom} & ~M5) | ((k % 2 == 0) ? 64'h1 << (16 * (k / 2) + 5) : 64'h0);
            take_irq();
            set_csr(4'h6);
        end
        results();
    end
endmodule // mss_scanner_tb

// ==== verilog/mss_pkg.sv ====
// Constants shared by the modem status scanner
package mss_pkg;
    localparam int          NUM_LINES   = 16;
    localparam int          LINE_W      = 4;
    localparam int          ADR_W       = 8;
    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_CSR     = 6'h00;
    localparam logic [5:0]  IDX_LINE    = 6'h02;
    // Control register fields
    localparam int          CSR_LINE_LO = 0;
    localparam int          CSR_STEP    = 4;
    localparam int          CSR_SCAN_EN = 5;
    localparam int          CSR_INT_EN  = 6;
    localparam int          CSR_CLEAR   = 7;
    localparam int          CSR_DONE    = 8;
    localparam int          CSR_CLRCYC  = 9;
    localparam int          CSR_OUT_LO  = 16;
    localparam int          CSR_IN_LO   = 20;
    // Outgoing control bits within a line word
    localparam int          OUT_LEN     = 0;
    localparam int          OUT_TRDY    = 1;
    localparam int          OUT_RTS     = 2;
    localparam int          OUT_STX     = 3;
    // Incoming status bits within a line word
    localparam int          IN_SRX      = 0;
    localparam int          IN_CTS      = 1;
    localparam int          IN_CAR      = 2;
    localparam int          IN_RING     = 3;
    // Bus request priority level
    localparam logic [2:0]  BR_LEVEL    = 3'h4;
    // Timing: one line every 1200 ns, four sequencer states per line
    localparam int          CLK_MHZ     = 250;
    localparam int          LINE_NS     = 1200;
    localparam int          STATE_NS    = LINE_NS / 4;
    localparam int          STATE_CYC   = (STATE_NS * CLK_MHZ) / 1000;
    localparam logic [7:0]  VECTOR_DEF  = 8'h30;
    typedef enum logic [2:0] {RC_REST, RC_INCR, RC_LOAD, RC_WRITE, RC_TEST} mss_rc_t;
    typedef enum logic [1:0] {IR_IDLE, IR_REQ, IR_XFER, IR_WAIT} mss_ir_t;
endpackage // mss_pkg

// ==== verilog/mss_scanner.sv ====
// Modem status scanner with Wishbone register access
//
// Our own choices: the register addresses and the Wishbone slave port.
module mss_scanner
    import mss_pkg::*;
#(
    parameter logic [7:0] VECTOR = VECTOR_DEF  // Arbitrary default vector
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [mss_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [15:0]          carrier_i,
    input  wire logic [15:0]          clear_to_send_i,
    input  wire logic [15:0]          secondary_receive_status_i,
    input  wire logic [15:0]          ring_i,
    output logic      [15:0]          terminal_ready_o,
    output logic      [15:0]          request_to_send_control_o,
    output logic      [15:0]          secondary_transmit_control_o,
    output logic                      bus_request_line_o,
    output logic      [2:0]           bus_request_level_o,
    input  wire logic                 bus_grant_i,
    output logic                      intr_xfer_o,
    output logic      [7:0]           intr_vector_o,
    input  wire logic                 intr_done_i
);
    import mss_pkg::*;

    logic                 ack_reg;
    logic [31:0]          dat_reg;
    logic [LINE_W-1:0]    line_counter;
    logic                 step_reg;
    logic                 scan_en_reg;
    logic                 interrupt_enable_bit;
    logic                 done_reg;
    logic                 clear_cyc_reg;
    logic [LINE_W-1:0]    clr_idx_reg;
    logic [3:0]           hold_reg;
    logic [3:0]           mem_reg [NUM_LINES];
    logic [15:0]          line_en_reg;
    logic [3:0]           stat_s1 [NUM_LINES];
    logic [3:0]           stat_s2 [NUM_LINES];
    logic [7:0]           div_reg;
    logic                 tick;
    mss_rc_t              rc_state;
    mss_ir_t              ir_state;
    logic                 acc, hit0, hit2, csr_wr, line_wr, scanner_clear;
    logic                 go, cond;
    logic [3:0]           cur_stat, cur_out;

    // Bus decode: new access only in the cycle before ack
    assign acc     = wb_cyc_i && wb_stb_i && !ack_reg;
    assign hit0    = wb_adr_i[ADR_W-1:2] == IDX_CSR;
    assign hit2    = wb_adr_i[ADR_W-1:2] == IDX_LINE;
    assign csr_wr  = acc && wb_we_i && hit0 && wb_sel_i[0];
    assign line_wr = acc && wb_we_i && hit2 && wb_sel_i[0];
    assign scanner_clear = csr_wr && wb_dat_i[CSR_CLEAR];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Status of the selected line, blinded unless its line is enabled
    assign cur_stat = line_en_reg[line_counter] ? stat_s2[line_counter] : 4'h0;
    assign cur_out  = {secondary_transmit_control_o[line_counter], request_to_send_control_o[line_counter],
                       terminal_ready_o[line_counter], line_en_reg[line_counter]};

    // Acknowledge one cycle after the request, then drop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= acc;
    end

    // Read data; unmapped addresses and select 2 return zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dat_reg <= 32'h0;
        end else if (acc) begin
            dat_reg <= 32'h0;
            if (!wb_we_i && hit0) begin
                dat_reg[CSR_LINE_LO +: LINE_W]         <= line_counter;
                dat_reg[CSR_STEP]                      <= step_reg;
                dat_reg[CSR_SCAN_EN]                   <= scan_en_reg;
                dat_reg[CSR_INT_EN]                    <= interrupt_enable_bit;
                dat_reg[CSR_DONE]                      <= done_reg;
                dat_reg[CSR_CLRCYC]                    <= clear_cyc_reg;
                dat_reg[CSR_OUT_LO +: 4]               <= cur_out;
                dat_reg[CSR_IN_LO +: 4]                <= cur_stat;
            end
        end
    end

    // Two-flop synchronisers for every modem input
    generate
        for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    stat_s1[i] <= 4'h0;
                    stat_s2[i] <= 4'h0;
                end else begin
                    stat_s1[i] <= {ring_i[i], carrier_i[i], clear_to_send_i[i], secondary_receive_status_i[i]};
                    stat_s2[i] <= stat_s1[i];
                end
            end
            // Outgoing controls latched only for the counted line
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    line_en_reg[i]                  <= 1'b0;
                    terminal_ready_o[i]             <= 1'b0;
                    request_to_send_control_o[i]    <= 1'b0;
                    secondary_transmit_control_o[i] <= 1'b0;
                end else if (line_wr && line_counter == LINE_W'(i)) begin
                    line_en_reg[i]                  <= wb_dat_i[OUT_LEN];
                    terminal_ready_o[i]             <= wb_dat_i[OUT_TRDY];
                    request_to_send_control_o[i]    <= wb_dat_i[OUT_RTS];
                    secondary_transmit_control_o[i] <= wb_dat_i[OUT_STX];
                end
            end
        end
    endgenerate

    // Scan state divider: one enable pulse per sequencer state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || div_reg == 8'(STATE_CYC - 1))
            div_reg <= 8'h0;
        else
            div_reg <= div_reg + 8'h1;
    end
    assign tick = div_reg == 8'(STATE_CYC - 1);

    // Program bits of the control register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scan_en_reg          <= 1'b0;
            interrupt_enable_bit <= 1'b0;
        end else if (scanner_clear) begin
            scan_en_reg          <= 1'b0;
            interrupt_enable_bit <= 1'b0;
        end else if (csr_wr) begin
            scan_en_reg          <= wb_dat_i[CSR_SCAN_EN];
            interrupt_enable_bit <= wb_dat_i[CSR_INT_EN];
        end
    end

    // Line counter: bus load wins over scan advance
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || scanner_clear)
            line_counter <= '0;
        else if (csr_wr)
            line_counter <= wb_dat_i[CSR_LINE_LO +: LINE_W];
        else if (tick && rc_state == RC_INCR)
            line_counter <= line_counter + LINE_W'(1);
    end

    // Step flag: one sequence, cleared by the advance
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || scanner_clear)
            step_reg <= 1'b0;
        else if (csr_wr)
            step_reg <= wb_dat_i[CSR_STEP];
        else if (tick && rc_state == RC_INCR)
            step_reg <= 1'b0;
    end

    // Clear sweep: zero every scan memory word, hold flops held clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || scanner_clear) begin
            clear_cyc_reg <= 1'b1;
            clr_idx_reg   <= '0;
        end else if (clear_cyc_reg) begin
            clr_idx_reg   <= clr_idx_reg + LINE_W'(1);
            if (clr_idx_reg == LINE_W'(NUM_LINES - 1))
                clear_cyc_reg <= 1'b0;
        end
    end

    // Sequencer: rest state plus four states per line
    assign go = (scan_en_reg && !done_reg) || step_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_cyc_reg) begin
            rc_state <= RC_REST;
        end else if (tick) begin
            case (rc_state)
                RC_REST:  if (go) rc_state <= RC_INCR;
                RC_INCR:  rc_state <= RC_LOAD;
                RC_LOAD:  rc_state <= RC_WRITE;
                RC_WRITE: rc_state <= RC_TEST;
                RC_TEST:  rc_state <= go ? RC_INCR : RC_REST;
                default:  rc_state <= RC_REST;
            endcase
        end
    end

    // Hold flops: last known status of the line
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_cyc_reg)
            hold_reg <= 4'h0;
        else if (tick && rc_state == RC_LOAD)
            hold_reg <= mem_reg[line_counter];
    end

    // Scan memory: zeroed by the sweep, written with current status
    always_ff @(posedge clk_i) begin
        if (clear_cyc_reg)
            mem_reg[clr_idx_reg] <= 4'h0;
        else if (tick && rc_state == RC_WRITE)
            mem_reg[line_counter] <= stat_s2[line_counter];
    end

    // Transition test: both edges except ring, which counts rising only
    assign cond = |((mem_reg[line_counter][2:0] ^ hold_reg[2:0])) ||
                  (mem_reg[line_counter][IN_RING] && !hold_reg[IN_RING]);

    // Done flag: set wins over a register write that clears it, except a scanner clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || scanner_clear)
            done_reg <= 1'b0;
        else if (tick && rc_state == RC_TEST && cond && line_en_reg[line_counter])
            done_reg <= 1'b1;
        else if (csr_wr)
            done_reg <= 1'b0;
    end

    // Interrupt master sequence: request, grant, transfer, wait for done low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ir_state <= IR_IDLE;
        end else begin
            case (ir_state)
                IR_IDLE: if (done_reg && interrupt_enable_bit) ir_state <= IR_REQ;
                IR_REQ:  if (!(done_reg && interrupt_enable_bit)) ir_state <= IR_IDLE;
                         else if (bus_grant_i) ir_state <= IR_XFER;
                IR_XFER: if (intr_done_i) ir_state <= IR_WAIT;
                IR_WAIT: if (!done_reg) ir_state <= IR_IDLE;
                default: ir_state <= IR_IDLE;
            endcase
        end
    end
    assign bus_request_line_o  = ir_state == IR_REQ;
    assign bus_request_level_o = BR_LEVEL;
    assign intr_xfer_o         = ir_state == IR_XFER;
    assign intr_vector_o       = intr_xfer_o ? VECTOR : 8'h0;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    localparam int TICK_GAP = STATE_CYC;

    unmapped_zero_a: assert property (acc && !hit0 |=> wb_dat_o == 32'h0)
        else $error("unmapped access returned data");
    ack_single_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");
    csr_load_a: assert property (csr_wr && !wb_dat_i[CSR_CLEAR] |=>
        line_counter == $past(wb_dat_i[3:0]) && scan_en_reg == $past(wb_dat_i[CSR_SCAN_EN]))
        else $error("control register not loaded");
    read_status_a: assert property (acc && !wb_we_i && hit0 |=>
        wb_dat_o[CSR_IN_LO +: 4] == $past(cur_stat) && wb_dat_o[CSR_OUT_LO +: 4] == $past(cur_out))
        else $error("line status read wrong");
    line_latch_a: assert property (line_wr |=>
        terminal_ready_o[$past(line_counter)] == $past(wb_dat_i[OUT_TRDY]))
        else $error("outgoing control not latched");
    req_gate_a: assert property (bus_request_line_o |-> $past(done_reg) && $past(interrupt_enable_bit))
        else $error("bus request without done and enable");
    req_level_a: assert property (done_reg && interrupt_enable_bit && ir_state == IR_IDLE
        |=> bus_request_line_o && bus_request_level_o == 3'h4)
        else $error("bus request not raised at level 4");
    tick_rate_a: assert property (tick |-> ##[TICK_GAP:TICK_GAP] tick)
        else $error("scan state rate wrong");
    seq_order_a: assert property (tick && rc_state == RC_INCR && !clear_cyc_reg
        |=> rc_state == RC_LOAD)
        else $error("sequencer order broken");
    ring_fall_a: assert property (tick && rc_state == RC_TEST && !done_reg && !csr_wr &&
        mem_reg[line_counter] == {1'b0, hold_reg[2:0]} |=> !done_reg)
        else $error("ring falling edge set done");
    done_set_a: assert property (tick && rc_state == RC_TEST && cond && line_en_reg[line_counter]
        && !scanner_clear |=> done_reg)
        else $error("done not set on transition");
    blind_a: assert property (acc && !wb_we_i && hit0 && !line_en_reg[line_counter]
        |=> wb_dat_o[CSR_IN_LO +: 4] == 4'h0)
        else $error("status visible on disabled line");
    clear_end_a: assert property ($rose(clear_cyc_reg) |-> ##[1:20] !clear_cyc_reg)
        else $error("clear sweep did not end");

    step_c: cover property (csr_wr && wb_dat_i[CSR_STEP] ##[1:400] rc_state == RC_TEST);
    irq_c: cover property (bus_request_line_o ##[1:20] intr_xfer_o);
    read_c: cover property (acc && !wb_we_i && hit0 && cur_stat != 4'h0);
endmodule // mss_scanner
